//--- rtl/eca_pkg.sv
// constants and carriers for the echo canceller auxiliary control registers
// assumes an 8-bit synchronous processor port and a 25 MHz core clock
package eca_pkg;
	localparam int ADDR_W = 7;
	localparam logic [6:0] OFF_WRITE_PROT = 7'h01;
	localparam logic [6:0] OFF_SCU_A = 7'h12;
	localparam logic [6:0] OFF_SCU_B = 7'h13;
	localparam logic [6:0] OFF_SCU_C = 7'h14;
	localparam logic [6:0] OFF_SCU_D = 7'h15;
	localparam logic [6:0] OFF_TS16_CFG = 7'h31;
	localparam logic [6:0] OFF_IDLE_CFG = 7'h32;
	localparam logic [6:0] OFF_IDLE_MASK = 7'h33;
	localparam logic [6:0] OFF_IDLE_PAT = 7'h34;
	localparam logic [6:0] OFF_TEST_ADDR = 7'h35;
	localparam logic [6:0] OFF_TIMER_CTRL = 7'h37;
	localparam logic [6:0] OFF_TEST_CTRL = 7'h38;
	localparam logic [6:0] OFF_TX_PAT = 7'h39;
	localparam logic [6:0] OFF_RX_PAT = 7'h3a;
	localparam logic [6:0] OFF_TIM_HI = 7'h3b;
	localparam logic [6:0] OFF_TIM_LO = 7'h3c;
	localparam logic [6:0] OFF_HW_CFG = 7'h60;
	localparam logic [6:0] OFF_HW_ALIGN = 7'h61;
	localparam logic [6:0] OFF_SPEC_SEL = 7'h62;
	localparam logic [6:0] OFF_RAM_ACC = 7'h63;
	localparam logic [6:0] OFF_OUT_DATA = 7'h64;
	localparam logic [6:0] OFF_SPEC_MASK = 7'h65;
	localparam logic [6:0] OFF_CHAN_MASK = 7'h66;
	localparam logic [6:0] OFF_IN_DATA = 7'h67;
	localparam logic [6:0] OFF_STATUS = 7'h68;
	localparam logic [6:0] OFF_TIMER_HI_RD = 7'h69;
	localparam logic [6:0] OFF_TIMER_LO_RD = 7'h6a;
	localparam logic [6:0] OFF_MON_SEL = 7'h6f;
	localparam logic [7:0] UNLOCK_KEY = 8'h95;
	localparam logic [7:0] RST_SCU_A = 8'h69;
	localparam logic [7:0] RST_SCU_B = 8'h97;
	localparam logic [7:0] RST_SCU_C = 8'ha4;
	localparam logic [7:0] RST_SCU_D = 8'ha7;
	localparam logic [5:0] RST_TS16_CFG = 6'h12;
	localparam logic [5:0] RST_IDLE_CFG = 6'h1d;
	localparam logic [7:0] RST_IDLE_PAT = 8'h55;
	localparam logic [7:0] RST_TEST_PAT = 8'h55;
	localparam logic [7:0] RST_MON_SEL = 8'hfe;
	localparam int IDLE_SELF_BIT = 0;
	localparam int IDLE_SRC_BIT = 1;
	localparam int TIMER_RUN_BIT = 0;
	localparam int TEST_BIT = 1;
	localparam int RAM_DIR_BIT = 5;
	localparam int SPEC_LONG_EN_BIT = 6;
	localparam int HW_DIS_POS = 0;
	localparam int HW_FLEX_POS = 1;
	localparam int ST_IDLE_POS = 0;
	localparam int ST_TEST_EN_POS = 1;
	localparam int ST_TIMER_RUN_POS = 2;
	localparam int ST_TIMER_ZERO_POS = 3;
	localparam int ST_RAM_BUSY_POS = 4;
	localparam int RAM_READ_WAIT = 8;
	localparam int CLK_KHZ = 25000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
	localparam logic [3:0] MON_CODE_SECOND_LEVEL = 4'h2;
	localparam logic [3:0] MON_CODE_RX_TEST = 4'hc;
	localparam logic [3:0] MON_CODE_TX_TEST = 4'hd;
	typedef struct packed {
		logic [7:0] scu_a;
		logic [7:0] scu_b;
		logic [7:0] scu_c;
		logic [7:0] scu_d;
		logic [5:0] ts16_cfg;
		logic [6:0] hw_cfg;
		logic [7:0] test_ctrl;
		logic [7:0] tx_pat;
		logic [7:0] rx_pat;
	} cfg_out_t;
	typedef struct packed {
		logic valid;
		logic [4:0] frame;
		logic [7:0] data;
	} hw_byte_t;
endpackage

//--- rtl/echo_canceller_aux_control_regs.sv
// auxiliary control registers: monitor pins, idle detect, highway rams, test channel, timer
// assumes the processor port and the core status lines are on clk; frame pins are asynchronous
// How it works
// RQ1: codes 0-3 route idle, 2010 Hz first, second (pin one only), unprotected detect.
// RQ2: codes 4-7 route stability, fast convergence, double talk, subtractor bypass.
// RQ3: codes 8-11 route three 2100 Hz cases and no-voice.
// RQ4: codes 12, 13 route test streams, only in test channel slot, else zero.
// RQ5: codes 14, 15 route far-end and near-end speech-above-level flags.
// RQ6: idle compare against self or masked pattern; flag readable and routable.
// RQ7: idle mask bit one excludes that sample bit from comparison.
// RQ8: compare-select zero uses idle pattern, resetting to 55h.
// RQ9: long mode evaluates disable and flex bits only in processed channels.
// RQ10: alignment value numbers the first full frame after first frame sync.
// RQ11: five-bit field names the special common frame; others are channel frames.
// RQ12: long mode without long enable: no output nor enable for foreign frames; only highway_out_enable drops, highway_out still loads the ram byte.
// RQ13: access write with direction one copies output byte into output ram.
// RQ14: direction zero copies input ram byte to read data after 8 cycles.
// RQ15: special-frame mask bit one suppresses that bit's change interrupt.
// RQ16: channel-frame mask bit one suppresses that bit's change interrupt.
// RQ17: long mode change interrupt only for processed frames or long enable.
// RQ18: writing run bit one starts timer, zero stops it.
// RQ19: timer loads 16 bits from byte registers, counts down per millisecond.
// RQ20: test channel address picks reported channel and background test channel.
// RQ21: channel enabled externally during test raises abort interrupt.
// RQ22: external controls are ignored for the channel under background test.
// RQ23: protected registers writable only after key 95h; other value relocks.
// RQ24: configuration registers are write-only, read back as zero.
// RQ25: timer holds at zero, reloads on restart.
module echo_canceller_aux_control_regs #(
	parameter int TICK_LEN = eca_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic cpu_cs,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [eca_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	input wire logic [15:0] mon_status_in,
	input wire logic rx_path_test_stream,
	input wire logic tx_path_test_stream,
	input wire logic [4:0] current_slot,
	input wire logic sample_valid,
	input wire logic [7:0] rx_sample,
	input wire logic [7:0] tx_sample,
	input wire logic long_echo_mode,
	input wire logic [31:0] processed_channels,
	input wire logic [31:0] channel_enabled_in,
	input wire logic frame_sync_in,
	input wire logic bit_clock_in,
	input wire logic frame_start,
	input wire eca_pkg::hw_byte_t highway_in,
	output logic monitor_pin_one,
	output logic monitor_pin_two,
	output logic idle_status_flag,
	output logic [4:0] highway_frame_no,
	output logic [7:0] highway_out,
	output logic highway_out_enable,
	output logic highway_change_irq,
	output logic highway_disable_bit,
	output logic highway_flex_bit,
	output logic [4:0] highway_ctl_channel,
	output logic highway_ctl_valid,
	output logic [4:0] test_channel,
	output logic software_test_bit,
	output logic test_channel_enabled_flag,
	output logic test_abort_irq,
	output logic timer_zero,
	output eca_pkg::cfg_out_t cfg_out
);
	import eca_pkg::*;

	logic rst_a_r, rst_n_r;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_a_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_a_r <= 1'b1;
			rst_n_r <= rst_a_r;
		end
	end

	// frame pins: third flop agreement filters a glitch at the sampling edge
	logic [2:0] sync_sh_r, sclk_sh_r;
	logic sync_lvl_r, sclk_lvl_r;
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			sync_sh_r <= 3'h0;
			sclk_sh_r <= 3'h0;
			sync_lvl_r <= 1'b0;
			sclk_lvl_r <= 1'b0;
		end
		else if (ce)
		begin
			sync_sh_r <= {sync_sh_r[1:0], frame_sync_in};
			sclk_sh_r <= {sclk_sh_r[1:0], bit_clock_in};
			if (sync_sh_r[1] == sync_sh_r[2])
				sync_lvl_r <= sync_sh_r[2];
			if (sclk_sh_r[1] == sclk_sh_r[2])
				sclk_lvl_r <= sclk_sh_r[2];
		end
	end
	logic sclk_fall;
	assign sclk_fall = sclk_lvl_r && (sclk_sh_r[1] == sclk_sh_r[2]) && !sclk_sh_r[2];

	// register writes
	logic wr_en, unlocked_r;
	logic [7:0] scu_a_r, scu_b_r, scu_c_r, scu_d_r, idle_mask_r, idle_pat_r, mon_sel_r;
	logic [7:0] test_ctrl_r, tx_pat_r, rx_pat_r, tim_hi_r, tim_lo_r;
	logic [7:0] out_data_r, spec_mask_r, chan_mask_r;
	logic [5:0] ts16_r, idle_cfg_r, ram_acc_r;
	logic [6:0] hw_cfg_r, spec_sel_r;
	logic [4:0] test_addr_r, align_r;
	logic [1:0] timer_ctrl_r;
	assign wr_en = ce && cpu_cs && cpu_wr;

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			unlocked_r <= 1'b0;
		else if (wr_en && cpu_addr == OFF_WRITE_PROT)
			unlocked_r <= (cpu_wdata == UNLOCK_KEY); // RQ23
	end

	// protected group: the lock keeps a stray write from retuning live processing
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			scu_a_r <= RST_SCU_A;
			scu_b_r <= RST_SCU_B;
			scu_c_r <= RST_SCU_C;
			scu_d_r <= RST_SCU_D;
			ts16_r <= RST_TS16_CFG;
			idle_cfg_r <= RST_IDLE_CFG;
			idle_mask_r <= 8'h00;
			idle_pat_r <= RST_IDLE_PAT;
			test_addr_r <= 5'h00;
			timer_ctrl_r <= 2'h0;
			hw_cfg_r <= 7'h00;
			align_r <= 5'h00;
			spec_sel_r <= 7'h00;
		end
		else if (wr_en && unlocked_r) // RQ23
		begin
			case (cpu_addr)
				OFF_SCU_A: scu_a_r <= cpu_wdata;
				OFF_SCU_B: scu_b_r <= cpu_wdata;
				OFF_SCU_C: scu_c_r <= cpu_wdata;
				OFF_SCU_D: scu_d_r <= cpu_wdata;
				OFF_TS16_CFG: ts16_r <= cpu_wdata[5:0];
				OFF_IDLE_CFG: idle_cfg_r <= cpu_wdata[5:0];
				OFF_IDLE_MASK: idle_mask_r <= cpu_wdata;
				OFF_IDLE_PAT: idle_pat_r <= cpu_wdata;
				OFF_TEST_ADDR: test_addr_r <= cpu_wdata[4:0];
				OFF_TIMER_CTRL: timer_ctrl_r <= cpu_wdata[1:0];
				OFF_HW_CFG: hw_cfg_r <= cpu_wdata[6:0];
				OFF_HW_ALIGN: align_r <= cpu_wdata[4:0];
				OFF_SPEC_SEL: spec_sel_r <= cpu_wdata[6:0];
				default: ;
			endcase
		end
	end

	// unprotected group
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			mon_sel_r <= RST_MON_SEL;
			test_ctrl_r <= 8'h00;
			tx_pat_r <= RST_TEST_PAT;
			rx_pat_r <= RST_TEST_PAT;
			tim_hi_r <= 8'h00;
			tim_lo_r <= 8'h00;
			ram_acc_r <= 6'h00;
			out_data_r <= 8'h00;
			spec_mask_r <= 8'h00;
			chan_mask_r <= 8'h00;
		end
		else if (wr_en)
		begin
			case (cpu_addr)
				OFF_MON_SEL: mon_sel_r <= cpu_wdata;
				OFF_TEST_CTRL: test_ctrl_r <= cpu_wdata;
				OFF_TX_PAT: tx_pat_r <= cpu_wdata;
				OFF_RX_PAT: rx_pat_r <= cpu_wdata;
				OFF_TIM_HI: tim_hi_r <= cpu_wdata;
				OFF_TIM_LO: tim_lo_r <= cpu_wdata;
				OFF_RAM_ACC: ram_acc_r <= cpu_wdata[5:0];
				OFF_OUT_DATA: out_data_r <= cpu_wdata;
				OFF_SPEC_MASK: spec_mask_r <= cpu_wdata;
				OFF_CHAN_MASK: chan_mask_r <= cpu_wdata;
				default: ;
			endcase
		end
	end
	assign cfg_out = '{scu_a_r, scu_b_r, scu_c_r, scu_d_r, ts16_r, hw_cfg_r,
		test_ctrl_r, tx_pat_r, rx_pat_r};

	// idle detection
	logic [7:0] idle_smp, prev_smp_r, idle_ref;
	assign idle_smp = idle_cfg_r[IDLE_SRC_BIT] ? tx_sample : rx_sample; // RQ6
	assign idle_ref = idle_cfg_r[IDLE_SELF_BIT] ? prev_smp_r : idle_pat_r; // RQ8
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			prev_smp_r <= 8'h00;
			idle_status_flag <= 1'b0;
		end
		else if (ce && sample_valid)
		begin
			prev_smp_r <= idle_smp;
			idle_status_flag <= ((idle_smp ^ idle_ref) & ~idle_mask_r) == 8'h00; // RQ7
		end
	end

	// monitor pins
	logic test_slot, mon_one_nxt, mon_two_nxt;
	assign test_slot = current_slot == test_addr_r;
	function automatic logic mon_route(input logic [3:0] code, input logic pin_one,
		input logic idle, input logic slot, input logic [15:0] st,
		input logic rx_s, input logic tx_s);
		logic r;
		r = st[code];
		case (code)
			4'h0: r = idle; // RQ1
			MON_CODE_SECOND_LEVEL: r = pin_one & st[code]; // RQ1
			MON_CODE_RX_TEST: r = slot & rx_s; // RQ4
			MON_CODE_TX_TEST: r = slot & tx_s; // RQ4
			default: r = st[code]; // RQ2 RQ3 RQ5
		endcase
		return r;
	endfunction
	assign mon_one_nxt = mon_route(mon_sel_r[3:0], 1'b1, idle_status_flag, test_slot,
		mon_status_in, rx_path_test_stream, tx_path_test_stream);
	assign mon_two_nxt = mon_route(mon_sel_r[7:4], 1'b0, idle_status_flag, test_slot,
		mon_status_in, rx_path_test_stream, tx_path_test_stream);
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			monitor_pin_one <= 1'b0;
			monitor_pin_two <= 1'b0;
		end
		else if (ce)
		begin
			monitor_pin_one <= mon_one_nxt;
			monitor_pin_two <= mon_two_nxt;
		end
	end

	// highway multiframe numbering: armed by the first sync seen at a falling bit clock
	logic armed_r, aligned_r;
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			armed_r <= 1'b0;
			aligned_r <= 1'b0;
			highway_frame_no <= 5'h00;
		end
		else if (ce)
		begin
			if (!armed_r && sclk_fall && sync_lvl_r)
				armed_r <= 1'b1;
			if (frame_start && armed_r)
			begin
				aligned_r <= 1'b1;
				highway_frame_no <= aligned_r ? highway_frame_no + 5'd1 : align_r; // RQ10
			end
		end
	end

	// highway rams, flop based
	logic [7:0] out_ram_r [32];
	logic [7:0] in_ram_r [32];
	logic [7:0] in_data_r;
	logic [3:0] rd_wait_r;
	logic foreign_frame, is_special;
	assign foreign_frame = long_echo_mode && !processed_channels[highway_frame_no];
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			for (int i = 0; i < 32; i++)
				out_ram_r[i] <= 8'h00;
		else if (wr_en && cpu_addr == OFF_RAM_ACC && cpu_wdata[RAM_DIR_BIT])
			out_ram_r[cpu_wdata[4:0]] <= out_data_r; // RQ13
	end
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			highway_out <= 8'h00;
			highway_out_enable <= 1'b0;
		end
		else if (ce)
		begin
			highway_out <= out_ram_r[highway_frame_no];
			// a second device on the same highway drives these frames
			highway_out_enable <= aligned_r && !(foreign_frame
				&& !spec_sel_r[SPEC_LONG_EN_BIT]); // RQ12
		end
	end

	// read path is timed, the byte lands RAM_READ_WAIT cycles after the access write
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			rd_wait_r <= 4'h0;
			in_data_r <= 8'h00;
		end
		else if (wr_en && cpu_addr == OFF_RAM_ACC && !cpu_wdata[RAM_DIR_BIT])
			rd_wait_r <= 4'(RAM_READ_WAIT); // RQ14
		else if (ce && rd_wait_r != 4'h0)
		begin
			rd_wait_r <= rd_wait_r - 4'h1;
			if (rd_wait_r == 4'h1)
				in_data_r <= in_ram_r[ram_acc_r[4:0]]; // RQ14
		end
	end

	// incoming highway bytes: change interrupt and control bit evaluation
	logic [7:0] chg_mask, changed;
	logic in_foreign, in_test_ch;
	assign is_special = highway_in.frame == spec_sel_r[4:0]; // RQ11
	assign chg_mask = is_special ? spec_mask_r : chan_mask_r; // RQ15 RQ16
	assign changed = (highway_in.data ^ in_ram_r[highway_in.frame]) & ~chg_mask;
	assign in_foreign = long_echo_mode && !processed_channels[highway_in.frame];
	assign in_test_ch = timer_ctrl_r[TEST_BIT] && highway_in.frame == test_addr_r;
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			for (int i = 0; i < 32; i++)
				in_ram_r[i] <= 8'h00;
			highway_change_irq <= 1'b0;
			highway_disable_bit <= 1'b0;
			highway_flex_bit <= 1'b0;
			highway_ctl_channel <= 5'h00;
			highway_ctl_valid <= 1'b0;
		end
		else if (ce)
		begin
			highway_change_irq <= highway_in.valid && changed != 8'h00
				&& (!in_foreign || spec_sel_r[SPEC_LONG_EN_BIT]); // RQ17
			highway_ctl_valid <= highway_in.valid && !in_foreign // RQ9
				&& !in_test_ch; // RQ22
			if (highway_in.valid)
			begin
				in_ram_r[highway_in.frame] <= highway_in.data;
				highway_disable_bit <= highway_in.data[HW_DIS_POS];
				highway_flex_bit <= highway_in.data[HW_FLEX_POS];
				highway_ctl_channel <= highway_in.frame;
			end
		end
	end

	// background test channel
	logic test_en_prev_r;
	assign test_channel = test_addr_r; // RQ20
	assign software_test_bit = timer_ctrl_r[TEST_BIT];
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			test_channel_enabled_flag <= 1'b0;
			test_en_prev_r <= 1'b0;
			test_abort_irq <= 1'b0;
		end
		else if (ce)
		begin
			test_channel_enabled_flag <= channel_enabled_in[test_addr_r]; // RQ20
			test_en_prev_r <= test_channel_enabled_flag;
			test_abort_irq <= timer_ctrl_r[TEST_BIT] && test_channel_enabled_flag
				&& !test_en_prev_r; // RQ21
		end
	end

	// millisecond timer; a start clears the tick count, so the first decrement comes one full tick later
	logic [15:0] timer_r;
	logic [31:0] tick_r;
	logic timer_run_r;
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			timer_r <= 16'h0000;
			tick_r <= 32'h0;
			timer_run_r <= 1'b0;
		end
		else if (wr_en && unlocked_r && cpu_addr == OFF_TIMER_CTRL)
		begin
			timer_run_r <= cpu_wdata[TIMER_RUN_BIT]; // RQ18
			if (cpu_wdata[TIMER_RUN_BIT])
			begin
				timer_r <= {tim_hi_r, tim_lo_r}; // RQ19 RQ25
				tick_r <= 32'h0;
			end
		end
		else if (ce && timer_run_r && timer_r != 16'h0000) // RQ25
		begin
			if (tick_r == 32'(TICK_LEN - 1))
			begin
				tick_r <= 32'h0;
				timer_r <= timer_r - 16'h0001; // RQ19
			end
			else
				tick_r <= tick_r + 32'h1;
		end
	end
	assign timer_zero = timer_r == 16'h0000;

	// read mux: write group reads zero
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			cpu_rdata <= 8'h00;
		else if (ce && cpu_cs && cpu_rd)
		begin
			case (cpu_addr)
				OFF_IN_DATA: cpu_rdata <= in_data_r;
				OFF_STATUS: cpu_rdata <= 8'({rd_wait_r != 4'h0, timer_zero, timer_run_r,
					test_channel_enabled_flag, idle_status_flag});
				OFF_TIMER_HI_RD: cpu_rdata <= timer_r[15:8];
				OFF_TIMER_LO_RD: cpu_rdata <= timer_r[7:0];
				default: cpu_rdata <= 8'h00; // RQ24
			endcase
		end
	end
endmodule

//--- bench/eca_aux_assertions.sv
// port checker for the auxiliary control registers
// assumes it is bound to the top module and sees only its ports
module eca_aux_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic cpu_cs,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [eca_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic [7:0] cpu_rdata,
	input wire eca_pkg::hw_byte_t highway_in,
	input wire logic long_echo_mode,
	input wire logic [31:0] processed_channels,
	input wire logic highway_change_irq,
	input wire logic [4:0] highway_ctl_channel,
	input wire logic highway_ctl_valid,
	input wire logic [4:0] test_channel,
	input wire logic software_test_bit,
	input wire logic test_abort_irq,
	input wire logic timer_zero
);
	import eca_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	wire logic tctl_wr = cpu_cs && cpu_wr && cpu_addr == OFF_TIMER_CTRL;
	wire logic tadr_wr = cpu_cs && cpu_wr && cpu_addr == OFF_TEST_ADDR;
	sequence wo_read_s;
		cpu_cs && cpu_rd && ce && cpu_addr == OFF_SCU_A;
	endsequence
	sequence hw_taken_s;
		highway_in.valid ##1 1'b1;
	endsequence
	chk_wo_reads_zero: assert property (wo_read_s |=> cpu_rdata == 8'h00)
		else $error("write-only register returned data");
	chk_test_chan_src: assert property ($changed(test_channel) |-> $past(tadr_wr))
		else $error("test channel moved without a write");
	chk_abort_cause: assert property (test_abort_irq |-> $past(software_test_bit))
		else $error("abort request without a running test");
	chk_abort_pulse: assert property (test_abort_irq |=> !test_abort_irq)
		else $error("abort request longer than one cycle");
	chk_irq_source: assert property (highway_change_irq |-> $past(highway_in.valid))
		else $error("highway change flagged without a received byte");
	chk_ctl_long: assert property (highway_ctl_valid && long_echo_mode |->
		processed_channels[highway_ctl_channel])
		else $error("highway control for a foreign channel");
	chk_ctl_test_skip: assert property (highway_ctl_valid |->
		!(software_test_bit && highway_ctl_channel == test_channel))
		else $error("highway control reached the channel under test");
	chk_timer_hold: assert property (timer_zero && !tctl_wr |=> timer_zero)
		else $error("timer left zero without a restart");
	chk_timer_start: assert property ($fell(timer_zero) |-> $past(tctl_wr))
		else $error("timer started without a run write");
	cov_highway: cover property (hw_taken_s ##0 highway_change_irq);
endmodule

bind echo_canceller_aux_control_regs eca_aux_checker eca_aux_checker_inst (
	.clk(clk), .arst_n(arst_n), .ce(ce), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
	.cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .highway_in(highway_in),
	.long_echo_mode(long_echo_mode), .processed_channels(processed_channels),
	.highway_change_irq(highway_change_irq), .highway_ctl_channel(highway_ctl_channel),
	.highway_ctl_valid(highway_ctl_valid), .test_channel(test_channel),
	.software_test_bit(software_test_bit), .test_abort_irq(test_abort_irq),
	.timer_zero(timer_zero)
);

//--- bench/eca_host_model.sv
// host processor model: single-cycle register strobes on the rising edge
// assumes the block takes a strobe at the first rising edge it is seen
module eca_host_model (
	input wire logic clk,
	output logic cpu_cs,
	output logic cpu_wr,
	output logic cpu_rd,
	output logic [eca_pkg::ADDR_W-1:0] cpu_addr,
	output logic [7:0] cpu_wdata,
	input wire logic [7:0] cpu_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import eca_pkg::*;
	initial
	begin
		{cpu_cs, cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = '0;
	end
	// released lines flip so stale values never look valid
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		cpu_cs = 1'b1;
		cpu_wr = 1'b1;
		cpu_addr = a;
		cpu_wdata = d;
		@(posedge clk);
		#1;
		cpu_cs = 1'b0;
		cpu_wr = 1'b0;
		cpu_addr = ~a;
		cpu_wdata = ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		cpu_cs = 1'b1;
		cpu_rd = 1'b1;
		cpu_addr = a;
		@(posedge clk);
		#1;
		cpu_cs = 1'b0;
		cpu_rd = 1'b0;
		cpu_addr = ~a;
		@(posedge clk);
		#1;
		d = cpu_rdata;
	endtask
	task automatic unlock();
		wr(OFF_WRITE_PROT, UNLOCK_KEY);
	endtask
	task automatic read_ram(input logic [4:0] a, output logic [7:0] d);
		wr(OFF_RAM_ACC, {3'h0, a});
		repeat (RAM_READ_WAIT) @(posedge clk);
		rd(OFF_IN_DATA, d);
	endtask
endmodule

//--- bench/echo_canceller_aux_control_regs_tb_top.sv
// self-checking bench for the auxiliary control registers
// assumes the host model owns the register port; the bench drives the rest
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module echo_canceller_aux_control_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import eca_pkg::*;
	localparam int TICK = 10;
	logic clk, arst_n, ce, cpu_cs, cpu_wr, cpu_rd, rx_ts, tx_ts, sample_valid, long_mode;
	logic frame_sync_in, bit_clock_in, frame_start, monitor_pin_one, monitor_pin_two;
	logic idle_status_flag, highway_change_irq, software_test_bit, test_en, test_abort_irq;
	logic timer_zero, seen, oe;
	logic [6:0] cpu_addr;
	logic [7:0] cpu_wdata, cpu_rdata, rx_sample, tx_sample, highway_out, rdv;
	logic [15:0] mon_status_in;
	logic [4:0] current_slot, highway_frame_no, test_channel;
	logic [31:0] processed, chan_en;
	hw_byte_t highway_in;
	cfg_out_t cfg_out;
	int failures = 0;
	int comparisons = 0;
	int n;
	logic [6:0] wo_list [10] = '{7'h12, 7'h14, 7'h31, 7'h32, 7'h34, 7'h35, 7'h3c, 7'h60, 7'h66,
		7'h7f};
	eca_host_model eca_host_model_inst (.clk(clk), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr),
		.cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
	echo_canceller_aux_control_regs #(.TICK_LEN(TICK)) echo_canceller_aux_control_regs_inst (
		.clk(clk), .arst_n(arst_n), .ce(ce), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.mon_status_in(mon_status_in), .rx_path_test_stream(rx_ts), .tx_path_test_stream(tx_ts),
		.current_slot(current_slot), .sample_valid(sample_valid), .rx_sample(rx_sample),
		.tx_sample(tx_sample), .long_echo_mode(long_mode), .processed_channels(processed),
		.channel_enabled_in(chan_en), .frame_sync_in(frame_sync_in),
		.bit_clock_in(bit_clock_in), .frame_start(frame_start), .highway_in(highway_in),
		.monitor_pin_one(monitor_pin_one), .monitor_pin_two(monitor_pin_two),
		.idle_status_flag(idle_status_flag), .highway_frame_no(highway_frame_no),
		.highway_out(highway_out), .highway_out_enable(oe), .highway_change_irq(highway_change_irq),
		.highway_disable_bit(), .highway_flex_bit(), .highway_ctl_channel(),
		.highway_ctl_valid(), .test_channel(test_channel), .software_test_bit(software_test_bit),
		.test_channel_enabled_flag(test_en), .test_abort_irq(test_abort_irq),
		.timer_zero(timer_zero), .cfg_out(cfg_out));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic test_done();
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// irq is caught over a short window, latency is the design's choice
	task automatic hwb(input logic [4:0] f, input logic [7:0] d);
		step(1);
		highway_in = '{valid: 1'b1, frame: f, data: d};
		step(1);
		highway_in = '{valid: 1'b0, frame: ~f, data: ~d};
		seen = 1'b0;
		repeat (3)
		begin
			seen = seen | (highway_change_irq === 1'b1);
			step(1);
		end
	endtask
	task automatic idle_sample(input logic [7:0] d);
		step(1);
		rx_sample = d;
		sample_valid = 1'b1;
		step(1);
		sample_valid = 1'b0;
		rx_sample = ~d;
		step(3);
	endtask
	initial
	begin
		{arst_n, sample_valid, long_mode, frame_sync_in, bit_clock_in, frame_start} = '0;
		{ce, rx_ts, tx_ts} = 3'b111;
		{rx_sample, tx_sample, mon_status_in, current_slot, chan_en} = '0;
		processed = 32'h0f0f_000f;
		highway_in = '0;
		repeat (16) @(posedge clk);
		#1;
		arst_n = 1'b1;
		step(4);
		`CHK("cfg_rst", cfg_out_t'{8'h69, 8'h97, 8'ha4, 8'ha7, 6'h12, 7'h00, 8'h00, 8'h55,
			8'h55}, cfg_out)
		foreach (wo_list[i])
		begin
			eca_host_model_inst.rd(wo_list[i], rdv);
			`CHK("rd_zero", 8'h00, rdv)
		end
		eca_host_model_inst.wr(7'h12, 8'h3c);
		step(1);
		`CHK("scu_locked", 8'h69, cfg_out.scu_a)
		eca_host_model_inst.unlock();
		eca_host_model_inst.wr(7'h12, 8'h3c);
		step(1);
		`CHK("scu_open", 8'h3c, cfg_out.scu_a)
		eca_host_model_inst.wr(7'h01, 8'h94);
		eca_host_model_inst.wr(7'h12, 8'h11);
		step(1);
		`CHK("scu_relock", 8'h3c, cfg_out.scu_a)
		eca_host_model_inst.unlock();
		for (int c = 1; c < 16; c++)
		begin
			mon_status_in = 16'h0001 << c;
			eca_host_model_inst.wr(7'h6f, {c[3:0], c[3:0]});
			step(3);
			`CHK("mon_one", 1'b1, monitor_pin_one)
			`CHK("mon_two", c != 2, monitor_pin_two)
			mon_status_in = 16'h0000;
			current_slot = 5'h09;
			step(3);
			`CHK("mon_off", 2'b00, {monitor_pin_one, monitor_pin_two})
			current_slot = 5'h00;
		end
		eca_host_model_inst.wr(7'h32, 8'h00);
		idle_sample(8'h55);
		`CHK("idle_pat", 1'b1, idle_status_flag)
		idle_sample(8'h54);
		`CHK("idle_diff", 1'b0, idle_status_flag)
		eca_host_model_inst.wr(7'h33, 8'h01);
		idle_sample(8'h54);
		`CHK("idle_mask", 1'b1, idle_status_flag)
		eca_host_model_inst.wr(7'h6f, 8'h00);
		step(3);
		`CHK("mon_idle", 2'b11, {monitor_pin_one, monitor_pin_two})
		hwb(5'h05, 8'ha5);
		hwb(5'h05, 8'ha5);
		`CHK("irq_same", 1'b0, seen)
		eca_host_model_inst.wr(7'h66, 8'h01);
		hwb(5'h05, 8'ha4);
		`CHK("irq_masked", 1'b0, seen)
		hwb(5'h05, 8'ha6);
		`CHK("irq_open", 1'b1, seen)
		eca_host_model_inst.wr(7'h65, 8'hff);
		hwb(5'h00, 8'hf0);
		`CHK("irq_spec_mask", 1'b0, seen)
		eca_host_model_inst.wr(7'h65, 8'h00);
		hwb(5'h00, 8'hf1);
		`CHK("irq_spec", 1'b1, seen)
		eca_host_model_inst.read_ram(5'h05, rdv);
		`CHK("ram_read", 8'ha6, rdv)
		eca_host_model_inst.wr(7'h3b, 8'h00);
		eca_host_model_inst.wr(7'h3c, 8'h03);
		eca_host_model_inst.wr(7'h37, 8'h01);
		`CHK("timer_run", 1'b0, timer_zero)
		for (n = 0; timer_zero !== 1'b1 && n < 200; n++)
			step(1);
		`CHK("timer_span", 1'b1, n >= 3 * TICK && n <= 4 * TICK)
		if (n >= 200)
			test_done();
		step(20);
		`CHK("timer_hold", 1'b1, timer_zero)
		eca_host_model_inst.wr(7'h37, 8'h01);
		`CHK("timer_reload", 1'b0, timer_zero)
		eca_host_model_inst.wr(7'h37, 8'h00);
		step(60);
		`CHK("timer_stop", 1'b0, timer_zero)
		eca_host_model_inst.wr(7'h35, 8'h04);
		step(2);
		`CHK("test_chan", 5'h04, test_channel)
		`CHK("test_en_off", 1'b0, test_en)
		eca_host_model_inst.wr(7'h37, 8'h02);
		step(1);
		`CHK("test_bit", 1'b1, software_test_bit)
		hwb(5'h04, 8'h03);
		chan_en = 32'h0000_0010;
		seen = 1'b0;
		repeat (6)
		begin
			seen = seen | (test_abort_irq === 1'b1);
			step(1);
		end
		`CHK("abort_irq", 1'b1, seen)
		`CHK("test_en_on", 1'b1, test_en)
		eca_host_model_inst.wr(7'h37, 8'h00);
		step(1);
		`CHK("test_end", 1'b0, software_test_bit)
		eca_host_model_inst.wr(7'h64, 8'h3c);
		eca_host_model_inst.wr(7'h63, 8'h28);
		eca_host_model_inst.wr(7'h61, 8'h07);
		{frame_sync_in, bit_clock_in} = 2'b11;
		step(6);
		bit_clock_in = 1'b0;
		step(6);
		{frame_sync_in, bit_clock_in} = 2'b01;
		for (int k = 0; k < 2; k++)
		begin
			frame_start = 1'b1;
			step(1);
			frame_start = 1'b0;
			step(2);
			`CHK("frame_no", 5'h07 + 5'(k), highway_frame_no)
		end
		`CHK("ram_out", 8'h3c, highway_out)
		long_mode = 1'b1;
		hwb(5'h08, 8'h0f);
		`CHK("irq_foreign", 1'b0, seen)
		`CHK("oe_off", 1'b0, oe)
		test_done();
	end
endmodule
